// *** verilog/lpp_pkg.sv ***
// ============================================================
// shared constants and carriers of the pattern playback engine
// ============================================================
package lpp_pkg;

    // sample word and pattern length fields
    localparam int LPP_SAMPLE_W   = 16;
    localparam int LPP_LEN_W      = 30;
    localparam int LPP_WORDS_W    = LPP_LEN_W + 2;
    localparam int LPP_ALIGN_BITS = 5;       // lengths step in 32 samples

    localparam logic [LPP_ALIGN_BITS-1:0] LPP_ALIGN_ZERO = 5'h00;
    localparam logic [LPP_LEN_W-1:0] LPP_MIN_LEN = 30'h0000_1000;
    localparam logic [LPP_LEN_W-1:0] LPP_MAX_LEN = 30'h2000_0000;

    // sample codes: sign bit flip turns two's complement into offset
    localparam logic [LPP_SAMPLE_W-1:0] LPP_SIGN_BIT  = 16'h8000;
    localparam logic [LPP_SAMPLE_W-1:0] LPP_ZERO_CODE = 16'h0000;

    // converter clock presence timeout, longest time so rounded down
    localparam int LPP_CLK_PERIOD_NS = 5;
    localparam int LPP_CLK_LOSS_NS   = 1000;
    localparam int LPP_CLK_LOSS_CYC  = LPP_CLK_LOSS_NS / LPP_CLK_PERIOD_NS;
    localparam int LPP_LOSS_W        = 8;
    localparam logic [LPP_LOSS_W-1:0] LPP_LOSS_LAST =
        LPP_LOSS_W'(LPP_CLK_LOSS_CYC - 1);

    // channel interleave modes
    typedef enum logic [1:0] {
        LPP_CH1,
        LPP_CH2,
        LPP_CH4
    } lpp_chan_e;

    typedef struct packed {
        lpp_chan_e                chan;
        logic                     offset_bin;
        logic [LPP_LEN_W-1:0]     len;
        logic [LPP_LEN_W-1:0]     lead;
    } lpp_cfg_s;

    typedef struct packed {
        logic second_pll_status_led;
        logic converter_clock_led;
        logic tx_fifo_overflow_led;
    } lpp_led_s;

endpackage

// *** verilog/lpp_sync.sv ***
`timescale 1ns/1ps
// ============================================================
// two flop synchroniser for levels from outside the clock domain
// ============================================================
module lpp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_clk_en,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } lpp_sync_s;

    lpp_sync_s q;
    lpp_sync_s d;

    // first stage feeds only the second stage
    always_comb begin
        d        = q;
        d.meta   = i_async;
        d.stable = q.meta;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '0;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    assign o_sync = q.stable;

endmodule

// *** verilog/lpp_fifo.sv ***
`timescale 1ns/1ps
// ============================================================
// transmit fifo between sample memory and converter link
// ============================================================
module lpp_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_clk_en,
    input  wire logic         i_flush,
    input  wire logic         i_valid,
    input  wire logic [W-1:0] i_data,
    output logic              o_ready,
    output logic              o_valid,
    output logic      [W-1:0] o_data,
    input  wire logic         i_ready
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wptr;
        logic [AW-1:0]           rptr;
        logic [AW:0]             cnt;
    } lpp_fifo_s;

    lpp_fifo_s q;
    lpp_fifo_s d;
    logic      push;
    logic      pop;

    // full and empty come straight from the fill count
    assign o_ready = q.cnt < (AW+1)'(DEPTH);
    assign o_valid = q.cnt != '0;
    assign o_data  = q.mem[q.rptr];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    // flush wins so a restart never replays stale words
    always_comb begin
        d = q;
        if (i_flush) begin
            d.wptr = '0;
            d.rptr = '0;
            d.cnt  = '0;
        end else begin
            if (push) begin
                d.mem[q.wptr] = i_data;
                d.wptr        = q.wptr + 1'b1;
            end
            if (pop) begin
                d.rptr = q.rptr + 1'b1;
            end
            d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '0;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    a_fifo_never_over: assert property (q.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
    a_fifo_push_count: assert property (
        i_clk_en && !i_flush && push && !pop |=> q.cnt == $past(q.cnt) + 1)
        else $error("fifo count missed a push");

endmodule

// *** verilog/lpp_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// RQ1 - whole pattern sits in sample memory before playback may start
// RQ2 - playback loops without end until a second send command stops it
// RQ3 - lead-in count defaults to zero and steps in 32 samples
// RQ4 - channel length 4096 to 512M samples, whole multiple of 32
// RQ5 - each loaded sample is a 16 bit signed integer
// RQ6 - one, two or four interleaved channels per pattern
// RQ7 - output coding selectable: two's complement or offset binary
// RQ8 - transmit fifo fault lights a sticky error indicator
// RQ9 - no converter clock turns both clock indicators off
// RQ10 - second pll indicator stays off, that pll is unused
// RQ11 - converter board supplies the clock that paces transmission
// RQ12 - after loop end resume at loop start, no gap, no lead-in replay
module lpp_top #(
    parameter int MEM_DEPTH  = 8192,
    parameter int AW         = $clog2(MEM_DEPTH),
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                                i_sys_clk,
    input  wire logic                                i_resetn,
    input  wire logic                                i_clk_en,
    input  wire logic                                i_link_clk,
    input  wire lpp_pkg::lpp_cfg_s                   i_cfg,
    input  wire logic                                i_send,
    input  wire logic                                i_load_clear,
    input  wire logic                                i_load_valid,
    input  wire logic [lpp_pkg::LPP_SAMPLE_W-1:0]    i_load_data,
    output logic                                     o_load_ready,
    output logic                                     o_loaded,
    output logic                                     o_playing,
    output logic                                     o_cfg_error,
    output logic      [lpp_pkg::LPP_SAMPLE_W-1:0]    o_dac_data,
    output logic      [1:0]                          o_dac_chan,
    output logic                                     o_dac_valid,
    output lpp_pkg::lpp_led_s                        o_led
);

    // ============================================================
    // state
    // ============================================================
    typedef enum logic {
        LPP_IDLE,
        LPP_PLAY
    } lpp_st_e;

    typedef struct packed {
        lpp_st_e                                       st;
        logic [MEM_DEPTH-1:0][lpp_pkg::LPP_SAMPLE_W-1:0] mem;
        logic [AW:0]                                   wr_cnt;
        logic [AW-1:0]                                 rd_ptr;
        logic [AW-1:0]                                 last;
        logic [AW-1:0]                                 loop;
        logic                                          offset_bin;
        logic [1:0]                                    ch_mask;
        logic [1:0]                                    chan;
        logic                                          primed;
        logic                                          link_prev;
        logic [lpp_pkg::LPP_LOSS_W-1:0]                idle_cnt;
        logic                                          load_ready;
        logic                                          loaded;
        logic                                          playing;
        logic                                          cfg_err;
        logic [lpp_pkg::LPP_SAMPLE_W-1:0]              dac_data;
        logic                                          dac_valid;
        lpp_pkg::lpp_led_s                             led;
    } lpp_top_s;

    lpp_top_s q;
    lpp_top_s d;

    logic                                link_s;
    logic                                link_edge;
    logic [lpp_pkg::LPP_WORDS_W-1:0]     words;
    logic [lpp_pkg::LPP_WORDS_W-1:0]     lead_words;
    logic [1:0]                          ch_mask;
    logic                                cfg_ok;
    logic                                load_ok;
    logic                                start;
    logic                                stop;
    logic                                fifo_in_valid;
    logic                                fifo_in_ready;
    logic [lpp_pkg::LPP_SAMPLE_W-1:0]    fifo_in_data;
    logic                                fifo_out_valid;
    logic                                fifo_out_ready;
    logic [lpp_pkg::LPP_SAMPLE_W-1:0]    fifo_out_data;
    logic                                push;
    logic                                pop;

    // ============================================================
    // converter clock sampling
    // ============================================================
    // the converter clock is slow against ours, so sampling it and
    // finding its rising edge is cheaper than a second domain
    lpp_sync #(
        .W (1)
    ) u_link_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_clk_en  (i_clk_en),
        .i_async   (i_link_clk),
        .o_sync    (link_s)
    );

    assign link_edge = link_s && !q.link_prev;  // see RQ11

    // ============================================================
    // pattern geometry and configuration check
    // ============================================================
    // word counts scale by channel count; an illegal mode yields zero
    always_comb begin
        unique case (i_cfg.chan)
            lpp_pkg::LPP_CH1: begin
                words      = {2'b00, i_cfg.len};
                lead_words = {2'b00, i_cfg.lead};
                ch_mask    = 2'b00;
            end
            lpp_pkg::LPP_CH2: begin
                words      = {1'b0, i_cfg.len, 1'b0};
                lead_words = {1'b0, i_cfg.lead, 1'b0};
                ch_mask    = 2'b01;             // see RQ6
            end
            lpp_pkg::LPP_CH4: begin
                words      = {i_cfg.len, 2'b00};
                lead_words = {i_cfg.lead, 2'b00};
                ch_mask    = 2'b11;             // see RQ6
            end
            default: begin
                words      = '0;
                lead_words = '0;
                ch_mask    = 2'b00;
            end
        endcase
    end

    // a pattern that does not fit memory is refused, not truncated
    assign cfg_ok =
        (i_cfg.len[lpp_pkg::LPP_ALIGN_BITS-1:0] ==
            lpp_pkg::LPP_ALIGN_ZERO) &&             // see RQ4
        (i_cfg.lead[lpp_pkg::LPP_ALIGN_BITS-1:0] ==
            lpp_pkg::LPP_ALIGN_ZERO) &&             // see RQ3
        (i_cfg.len >= lpp_pkg::LPP_MIN_LEN) &&
        (i_cfg.len <= lpp_pkg::LPP_MAX_LEN) &&
        (i_cfg.lead < i_cfg.len) &&
        (words != '0) &&
        (words <= lpp_pkg::LPP_WORDS_W'(MEM_DEPTH));

    assign load_ok = lpp_pkg::LPP_WORDS_W'(q.wr_cnt) >= words;  // see RQ1

    // send toggles between idle and playback
    assign start = i_send && (q.st == LPP_IDLE) && cfg_ok && load_ok;
    assign stop  = i_send && (q.st == LPP_PLAY);               // see RQ2

    // ============================================================
    // memory reader and transmit fifo
    // ============================================================
    assign fifo_in_valid  = (q.st == LPP_PLAY) && !stop;
    assign fifo_in_data   = q.mem[q.rd_ptr];
    assign push           = fifo_in_valid && fifo_in_ready;
    assign fifo_out_ready = (q.st == LPP_PLAY) && link_edge && !stop;
    assign pop            = fifo_out_valid && fifo_out_ready;

    lpp_fifo #(
        .W     (lpp_pkg::LPP_SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_clk_en  (i_clk_en),
        .i_flush   (start || stop),
        .i_valid   (fifo_in_valid),
        .i_data    (fifo_in_data),
        .o_ready   (fifo_in_ready),
        .o_valid   (fifo_out_valid),
        .o_data    (fifo_out_data),
        .i_ready   (fifo_out_ready)
    );

    // ============================================================
    // next state
    // ============================================================
    always_comb begin
        d              = q;
        d.link_prev    = link_s;
        d.led.second_pll_status_led = 1'b0;     // see RQ10

        // loading: only while idle, one signed 16 bit word per beat
        if (i_load_clear && q.st == LPP_IDLE) begin
            d.wr_cnt = '0;
        end else if (i_load_valid && q.load_ready) begin
            d.mem[q.wr_cnt[AW-1:0]] = i_load_data;  // see RQ5
            d.wr_cnt = q.wr_cnt + 1'b1;             // see RQ1
        end

        // start latches the geometry so a live change cannot tear it
        if (start) begin
            d.st         = LPP_PLAY;                // see RQ1
            d.rd_ptr     = '0;
            d.last       = AW'(words - 1'b1);
            d.loop       = AW'(lead_words);         // see RQ3
            d.offset_bin = i_cfg.offset_bin;
            d.ch_mask    = ch_mask;
            d.chan       = '0;
            d.primed     = 1'b0;
            d.cfg_err    = 1'b0;
            d.led.tx_fifo_overflow_led = 1'b0;
        end else if (i_send && q.st == LPP_IDLE) begin
            d.cfg_err = 1'b1;
        end else if (stop) begin
            d.st       = LPP_IDLE;                  // see RQ2
            d.dac_data = q.offset_bin ? lpp_pkg::LPP_SIGN_BIT
                                      : lpp_pkg::LPP_ZERO_CODE;
        end

        // wrap skips the lead-in and costs no cycle
        if (push) begin
            d.rd_ptr = (q.rd_ptr == q.last) ? q.loop     // see RQ12
                                            : q.rd_ptr + 1'b1;
        end
        if (q.st == LPP_PLAY && fifo_out_valid) begin
            d.primed = 1'b1;
        end

        // one word per converter clock edge, coded on the way out
        if (pop) begin
            d.dac_data = q.offset_bin ?
                fifo_out_data ^ lpp_pkg::LPP_SIGN_BIT :  // see RQ7
                fifo_out_data;
            d.chan     = (q.chan + 1'b1) & q.ch_mask;    // see RQ6
        end else if (fifo_out_ready && q.primed && !stop) begin
            // an edge with no word ready is a lost sample
            d.led.tx_fifo_overflow_led = 1'b1;           // see RQ8
        end

        // clock presence: edges keep the indicator on
        if (link_edge) begin
            d.idle_cnt = '0;
            d.led.converter_clock_led = 1'b1;
        end else if (q.idle_cnt == lpp_pkg::LPP_LOSS_LAST) begin
            d.led.converter_clock_led = 1'b0;            // see RQ9
        end else begin
            d.idle_cnt = q.idle_cnt + 1'b1;
        end

        d.playing    = (d.st == LPP_PLAY);
        d.dac_valid  = d.playing && d.primed;
        d.load_ready = (d.st == LPP_IDLE) &&
                       (d.wr_cnt < (AW+1)'(MEM_DEPTH));
        d.loaded     = lpp_pkg::LPP_WORDS_W'(d.wr_cnt) >= words;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '0;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign o_load_ready = q.load_ready;
    assign o_loaded     = q.loaded;
    assign o_playing    = q.playing;
    assign o_cfg_error  = q.cfg_err;
    assign o_dac_data   = q.dac_data;
    assign o_dac_chan   = q.chan;
    assign o_dac_valid  = q.dac_valid;
    assign o_led        = q.led;

    // ============================================================
    // checks
    // ============================================================
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_pop;
        i_clk_en && pop;
    endsequence

    sequence s_send_idle;
        i_clk_en && i_send && q.st == LPP_IDLE;
    endsequence

    a_start_needs_load: assert property ( // see RQ1
        $rose(q.playing) |-> $past(load_ok && cfg_ok))
        else $error("playback started without full pattern");

    a_load_held_off: assert property ( // see RQ1
        q.playing |-> !o_load_ready)
        else $error("load accepted during playback");

    a_stop_on_send: assert property ( // see RQ2
        i_clk_en && q.playing && i_send |=> !q.playing ##1 !o_dac_valid)
        else $error("send did not stop playback");

    a_bad_cfg_refused: assert property ( // see RQ4
        s_send_idle ##0 !cfg_ok |=> !q.playing && o_cfg_error)
        else $error("illegal geometry was accepted");

    a_loop_wrap: assert property ( // see RQ12
        i_clk_en && push && q.rd_ptr == q.last && !start
        |=> q.rd_ptr == q.loop)
        else $error("loop did not resume at loop start");

    a_out_coding: assert property ( // see RQ7
        s_pop |=> o_dac_data == ($past(fifo_out_data) ^
            ($past(q.offset_bin) ? lpp_pkg::LPP_SIGN_BIT
                                 : lpp_pkg::LPP_ZERO_CODE)))
        else $error("output coding wrong");

    a_chan_single: assert property ( // see RQ6
        s_pop ##0 q.ch_mask == 2'b00 |=> o_dac_chan == 2'b00)
        else $error("single channel index moved");

    a_fault_sticky: assert property ( // see RQ8
        i_clk_en && fifo_out_ready && !fifo_out_valid && q.primed && !stop
        |=> o_led.tx_fifo_overflow_led ##1 o_led.tx_fifo_overflow_led)
        else $error("fifo fault not flagged");

    a_clk_loss_off: assert property ( // see RQ9
        i_clk_en && !link_edge && q.idle_cnt == lpp_pkg::LPP_LOSS_LAST
        |=> !o_led.converter_clock_led && !o_led.second_pll_status_led)
        else $error("clock indicators on without clock");

    a_pll_led_off: assert property ( // see RQ10
        !o_led.second_pll_status_led)
        else $error("second pll indicator lit");

endmodule

// *** sim/lpp_dac_model.sv ***
`timescale 1ns/1ps
// ============================================================
// converter board: hands the sample clock back to the engine
// ============================================================
module lpp_dac_model (
    input  wire logic i_run,
    input  var  int   i_half_ps,
    output logic      o_link_clk
);
    // toggles only while running, parked low between runs so no
    // stray edge can pace the output outside a playback
    initial begin
        o_link_clk = 1'b0;
        forever begin
            #(1ps * (i_half_ps > 0 ? i_half_ps : 1));
            o_link_clk = i_run ? ~o_link_clk : 1'b0;
        end
    end
endmodule

// *** sim/lpp_top_tb.sv ***
`timescale 1ns/1ps
// ============================================================
// playback engine bench
// ============================================================
module lpp_top_tb;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic              lclk;
    logic              run = 1'b0;
    int                half_ps = 62500;
    lpp_pkg::lpp_cfg_s cfg = '0;
    logic              send = 1'b0;
    logic              clr = 1'b0;
    logic              ld_v = 1'b0;
    logic [15:0]       ld_d = 16'h0000;
    logic              ld_rdy, loaded, playing, cerr, dvalid;
    logic [15:0]       ddata, last;
    logic [1:0]        dchan, ch;
    lpp_pkg::lpp_led_s led;
    int                errors = 0;
    int                n_compared = 0;
    int                idx, w, e_len, e_lead, n0;
    logic              mon_on = 1'b0;
    logic              cke = 1'b1;
    logic [1:0]        chm = 2'h0;
    logic              obin, e;
    logic [62:0]       rows [10];

    // ============================================================
    // clock, far side and engine
    // ============================================================
    always #2.5 clk = ~clk;

    lpp_dac_model board (.i_run(run), .i_half_ps(half_ps),
        .o_link_clk(lclk));

    lpp_top #(.MEM_DEPTH(8192)) DUT (
        .i_sys_clk(clk), .i_resetn(resetn), .i_clk_en(cke),
        .i_link_clk(lclk), .i_cfg(cfg), .i_send(send),
        .i_load_clear(clr), .i_load_valid(ld_v), .i_load_data(ld_d),
        .o_load_ready(ld_rdy), .o_loaded(loaded), .o_playing(playing),
        .o_cfg_error(cerr), .o_dac_data(ddata), .o_dac_chan(dchan),
        .o_dac_valid(dvalid), .o_led(led));

    // ============================================================
    // shared tasks
    // ============================================================
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask

    // start or stop, then give the one-cycle answer time to land
    task automatic do_send;
        @(negedge clk) send = 1'b1;
        @(negedge clk) send = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    // distinct 16 bit words, so every new output word is seen
    function automatic logic [15:0] pat(input int i);
        return 16'(i) * 16'h0003 + 16'h0001;
    endfunction

    // one word per cycle into memory, ready must stand throughout
    task automatic load_words(input int from, input int upto);
        for (int i = from; i < upto; i++) begin
            cmp_bit(ld_rdy, 1'b1);
            ld_v = 1'b1;
            ld_d = pat(i);
            @(negedge clk);
        end
        ld_v = 1'b0;
    endtask

    // follows each new output word against the looped sequence
    always @(negedge clk) begin
        if (mon_on && dvalid && ddata !== last) begin
            w = idx < e_len ? idx
                : e_lead + (idx - e_len) % (e_len - e_lead);
            cmp_word(ddata, pat(w) ^ (obin ? 16'h8000 : 16'h0000));
            cmp_word(16'(dchan), 16'(2'(idx + 1) & chm));
            last = ddata;
            idx++;
        end
    end

    // a hang is cut short well past the planned run length
    initial begin
        #400us;
        errors++;
        stop_test();
    end

    // ============================================================
    // main sequence
    // ============================================================
    initial begin
        rows = '{{2'h0, 30'h1000, 30'h0, 1'b0},
                 {2'h0, 30'h1000, 30'h20, 1'b0},
                 {2'h0, 30'h1004, 30'h0, 1'b1},
                 {2'h0, 30'hFE0, 30'h0, 1'b1},
                 {2'h0, 30'h2000_0020, 30'h0, 1'b1},
                 {2'h0, 30'h1000, 30'h10, 1'b1},
                 {2'h0, 30'h1000, 30'h1000, 1'b1},
                 {2'h1, 30'h1000, 30'h0, 1'b1},
                 {2'h2, 30'h1000, 30'h0, 1'b1},
                 {2'h3, 30'h1000, 30'h0, 1'b1}};
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        cmp_word({10'h000, playing, cerr, dvalid, led}, 16'h0000);
        // single channel pattern of the minimum length
        load_words(0, 4096);
        cfg.len = 30'h1000;
        repeat (3) @(negedge clk);
        cmp_bit(loaded, 1'b1);
        run = 1'b1;
        // legal starts run and stop, the rest are refused
        foreach (rows[r]) begin
            {ch, cfg.len, cfg.lead, e} = rows[r];
            cfg.chan = lpp_pkg::lpp_chan_e'(ch);
            do_send();
            cmp_bit(cerr, e);
            cmp_bit(playing, ~e);
            if (!e) begin
                repeat (100) @(negedge clk);
                cmp_bit(playing, 1'b1);
                do_send();
                cmp_bit(playing, 1'b0);
            end
        end
        // lead-in then just over four loop passes, link run fast to save time
        cfg = '{lpp_pkg::LPP_CH1, 1'b0, 30'h1000, 30'hFE0};
        e_len = 4096;
        e_lead = 4064;
        obin = 1'b0;
        idx = 0;
        half_ps = 15000;
        last = ddata;
        mon_on = 1'b1;
        do_send();
        cmp_bit(cerr, 1'b0);
        for (int c = 0; c < 40000 && idx < 4200; c++) @(negedge clk);
        cmp_bit(1'(idx >= 4200), 1'b1);
        cmp_word({13'h0000, led}, 16'h0002);
        mon_on = 1'b0;
        do_send();
        cmp_bit(playing, 1'b0);
        // offset binary output at the nominal link rate
        cfg.offset_bin = 1'b1;
        cfg.lead = 30'h0;
        e_lead = 0;
        obin = 1'b1;
        idx = 0;
        half_ps = 62500;
        last = ddata;
        mon_on = 1'b1;
        do_send();
        for (int c = 0; c < 3000 && idx < 40; c++) @(negedge clk);
        cmp_bit(1'(idx >= 40), 1'b1);
        // clock enable low freezes playback, no word may move
        cke = 1'b0;
        @(negedge clk) n0 = idx;
        repeat (50) @(negedge clk);
        cmp_word(16'(idx - n0), 16'h0000);
        cmp_bit(playing, 1'b1);
        cke = 1'b1;
        mon_on = 1'b0;
        do_send();
        repeat (4) @(negedge clk);
        cmp_word(ddata, 16'h8000);
        // converter clock goes away
        run = 1'b0;
        repeat (250) @(negedge clk);
        cmp_word({13'h0000, led}, 16'h0000);
        // fill the rest of memory, then play two interleaved channels
        load_words(4096, 8192);
        cfg.chan = lpp_pkg::LPP_CH2;
        run = 1'b1;
        half_ps = 15000;
        chm = 2'h1;
        e_len = 8192;
        idx = 0;
        last = ddata;
        mon_on = 1'b1;
        do_send();
        cmp_bit(playing, 1'b1);
        for (int c = 0; c < 3000 && idx < 100; c++) @(negedge clk);
        cmp_bit(1'(idx >= 100), 1'b1);
        mon_on = 1'b0;
        do_send();
        cmp_bit(playing, 1'b0);
        // emptied memory refuses a start
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        repeat (2) @(negedge clk);
        cmp_bit(loaded, 1'b0);
        do_send();
        cmp_bit(cerr, 1'b1);
        cmp_bit(playing, 1'b0);
        stop_test();
    end
endmodule
